/* inc/csc_regs.svh */
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH
`define CSC_CLK_HZ 100000000
`define CSC_TICK_S 1
`define CSC_TICK_CYC (`CSC_CLK_HZ * `CSC_TICK_S)
`define CSC_ILV_S 1
`define CSC_ARST_S 180
`define CSC_AVG_S 180
`define CSC_MIN_S 60
`define CSC_ZC_PERMIL 15
`define CSC_NBANK 16
`define CSC_LOG_AW 10
`define CSC_LOGP0_MIN 60
`define CSC_LOGP1_MIN 30
`define CSC_LOGP2_MIN 15
`define CSC_LOGP3_MIN 10
`define CSC_A_CFG0 8'h00
`define CSC_A_CFG1 8'h04
`define CSC_A_FIXED 8'h08
`define CSC_A_CMD 8'h0C
`define CSC_A_THD 8'h10
`define CSC_A_LOGPER 8'h14
`define CSC_A_UNITID 8'h18
`define CSC_A_TOD 8'h1C
`define CSC_A_DATE 8'h20
`define CSC_A_STATUS 8'h24
`define CSC_A_FAULT 8'h28
`define CSC_A_LOGPTR 8'h2C
`define CSC_A_RATING 2'h1
`define CSC_A_COUNT 2'h2
`define CSC_F_STEPS 4:0
`define CSC_F_SF 12:8
`define CSC_F_ILV 16
`define CSC_F_HEN 17
`define CSC_F_HARST 18
`define CSC_F_CEN 19
`define CSC_F_OBEN 20
`define CSC_F_IWRAP 21
`define CSC_F_EWRAP 22
`define CSC_F_CORR 7:0
`define CSC_F_DIS 24:16
`define CSC_F_VLIM 7:0
`define CSC_F_ILIM 15:8
`define CSC_C_MRST 0
`define CSC_C_BATCLR 1
`define CSC_C_RTCINIT 2
`define CSC_C_ERASE 3
`define CSC_CFG0_RST 32'h004B_0F10
`define CSC_CFG1_RST 32'h000A_0032
`define CSC_THD_RST 32'h0000_0808
`define CSC_RATING_RST 8'h0C
`define CSC_UNITID_RST 32'h0000_0001
`endif

/* inc/csc_pkg.sv */
`include "csc_regs.svh"
package csc_pkg;
    // metering results, same clock as the block
    typedef struct packed {
        logic signed [15:0] demand;
        logic [9:0] load_permil;
        logic [2:0][7:0] vthd;
        logic [2:0][7:0] ithd;
        logic pf_low;
    } csc_meas_s;
    typedef struct packed {
        logic load;
        logic [23:0] tod;
        logic [23:0] date;
    } csc_rtc_s;
    typedef struct packed {
        logic wr;
        logic [`CSC_LOG_AW-1:0] addr;
    } csc_log_s;
    typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_ACT} csc_seq_e;
endpackage : csc_pkg

/* core/csc_tick.sv */
`timescale 1ns/1ps
module csc_tick #(
    parameter int unsigned CYC = 100
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset
    input wire logic ce, // clock enable
    output logic tick, // one-cycle pulse per second
    output logic blink // toggles every second
);
    logic [31:0] cnt;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 32'h0;
            tick <= 1'b0;
            blink <= 1'b0;
        end else if (ce) begin
            tick <= (cnt == CYC - 1);
            if (cnt == CYC - 1) begin
                cnt <= 32'h0;
                blink <= ~blink;
            end else begin
                cnt <= cnt + 32'h1;
            end
        end
    end
endmodule : csc_tick

/* core/csc_sync.sv */
`timescale 1ns/1ps
module csc_sync #(
    parameter int W = 4
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset
    input wire logic ce, // clock enable
    input wire logic [W-1:0] d, // asynchronous pins
    output logic [W-1:0] q // synchronised levels
);
    logic [W-1:0] s1;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= '0;
            q <= '0;
        end else if (ce) begin
            s1 <= d;
            q <= s1;
        end
    end
endmodule : csc_sync

/* core/csc_top.sv */
`timescale 1ns/1ps
`include "csc_regs.svh"
// Functional notes
// - only the first configured steps switch
// - no-action band is smallest rating times factor
// - wait correction interval before switching
// - discharge lockout after a bank turns off
// - optional gap between turn-ons, lasting until the next one-second tick
// - any connected bank may be fixed
// - per-bank rating, best-fitting bank chosen
// - per-bank ON counter, read-only, starts zero
// - load below 1.5 percent flags no current
// - harmonic overload switches all banks off
// - manual reset clears latch, indication follows distortion
// - harmonic auto-clear 180 s after recovery
// - supply fault instant, inhibits all turn-on
// - supply loss coded low, high, both
// - manual reset clears, re-raised while sensed
// - battery-low warning flashes until cleared
// - no logging while calendar clock stopped
// - interval log every 60/30/15/10 minutes
// - log period changes only after erase
// - unit identifier changes only after erase
// - logs wrap if enabled, else stop full
// - calendar loaded only on init command
// - three-minute average per phase raises harmonic fault
// - out-of-banks after two short cycles fully on
module csc_top #(
    parameter int unsigned TICK_CYC = `CSC_TICK_CYC
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset
    input wire logic ce, // clock enable
    input wire logic hsel, // ahb select
    input wire logic [31:0] haddr, // ahb address
    input wire logic [1:0] htrans, // ahb transfer type
    input wire logic hwrite, // ahb write
    input wire logic [2:0] hsize, // ahb size, word only
    input wire logic [31:0] hwdata, // ahb write data
    input wire logic hready, // ahb bus ready
    output logic hreadyout, // always ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // ahb read data
    input wire csc_pkg::csc_meas_s meas, // metering results
    input wire logic supply_low_ok_pin, // contactor supply banks 1-8
    input wire logic supply_high_ok_pin, // contactor supply banks 9-16
    input wire logic batt_low_pin, // backup battery low
    input wire logic rtc_run_pin, // calendar clock running
    output logic [15:0] bank_on, // contactor commands
    output logic no_load_current_flag, // load current too low
    output logic voltage_distortion_fault, // voltage thd indication
    output logic current_distortion_fault, // current thd indication
    output logic supply_loss_group_low, // banks 1-8 supply lost
    output logic supply_loss_group_high, // banks 9-16 supply lost
    output logic supply_loss_both_groups, // both supplies lost
    output logic batt_flash, // blinking battery warning
    output logic insufficient_capacity_flag, // out of banks
    output csc_pkg::csc_rtc_s calendar_clock, // calendar load strobe
    output csc_pkg::csc_log_s interval_log, // interval entry strobe
    output csc_pkg::csc_log_s event_log, // event entry strobe
    output logic [31:0] unit_identifier // eight bcd digits
);
    localparam int NB = `CSC_NBANK;
    localparam int AW = `CSC_LOG_AW;
    logic [31:0] cfg0, cfg1, fixed_r, thd_lim, tod_r, date_r, rd_mux;
    logic [1:0] log_per;
    logic [7:0] rating [NB];
    logic [31:0] op_cnt [NB];
    logic [8:0] lock_cnt [NB];
    logic [15:0] conn, auto_m, locked, next_bank_on;
    logic dp_wr, tick, blink;
    logic [7:0] dp_addr;
    logic [3:0] cmd, pins;
    logic [2:0] ok_lo, ok_hi;
    csc_pkg::csc_seq_e seq;
    logic [7:0] cor_cnt, min_rat;
    logic [1:0] ob_cnt;
    logic il_cnt, erased;
    logic [5:0][15:0] acc;
    logic [5:0] hi;
    logic [7:0] win_cnt, ar_cnt;
    logic vh_lat, ih_lat, vh_hi_q, ih_hi_q, clo, chi, batt_warn;
    logic [AW-1:0] iptr, eptr;
    logic ifull, efull;
    logic [5:0] sec_cnt, min_cnt, per_min;
    logic [6:0] evt_q, evt;
    logic [15:0] mag;
    logic [12:0] band;
    logic out_band, inhibit, fast_off, slot_free, ilog_go, elog_go;
    logic [4:0] on_idx, off_idx, fix_idx;
    logic on_ok, off_ok, fix_ok;

    wire ap = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign cmd = (dp_wr && dp_addr == `CSC_A_CMD) ? hwdata[3:0] : 4'h0;

    csc_tick #(.CYC(TICK_CYC)) u_tick (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .tick(tick), .blink(blink)
    );
    csc_sync #(.W(4)) u_sync (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .d({rtc_run_pin, batt_low_pin, supply_high_ok_pin, supply_low_ok_pin}),
        .q(pins)
    );

    // read data is picked in the address phase so the slave never waits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dp_wr <= 1'b0;
            dp_addr <= 8'h00;
            hrdata <= 32'h0;
        end else if (ce) begin
            dp_wr <= ap & hwrite;
            if (ap) dp_addr <= haddr[7:0];
            hrdata <= (ap & ~hwrite) ? rd_mux : 32'h0;
        end
    end

    always_comb begin
        rd_mux = 32'h0;
        case (haddr[7:0])
            `CSC_A_CFG0: rd_mux = cfg0;
            `CSC_A_CFG1: rd_mux = cfg1;
            `CSC_A_FIXED: rd_mux = fixed_r;
            `CSC_A_THD: rd_mux = thd_lim;
            `CSC_A_LOGPER: rd_mux = {30'h0, log_per};
            `CSC_A_UNITID: rd_mux = unit_identifier;
            `CSC_A_TOD: rd_mux = tod_r;
            `CSC_A_DATE: rd_mux = date_r;
            `CSC_A_STATUS: rd_mux = {10'h0, erased, ifull, efull, pins[3], seq, bank_on};
            `CSC_A_FAULT: rd_mux = {24'h0, evt, inhibit};
            `CSC_A_LOGPTR: rd_mux = {6'h0, eptr, 6'h0, iptr};
            default: begin
                if (haddr[7:6] == `CSC_A_RATING) rd_mux = {24'h0, rating[haddr[5:2]]};
                // counters readable only: no write path exists
                if (haddr[7:6] == `CSC_A_COUNT) rd_mux = op_cnt[haddr[5:2]];
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg0 <= `CSC_CFG0_RST;
            cfg1 <= `CSC_CFG1_RST;
            fixed_r <= 32'h0;
            thd_lim <= `CSC_THD_RST;
            tod_r <= 32'h0;
            date_r <= 32'h0;
        end else if (ce && dp_wr) begin
            case (dp_addr)
                `CSC_A_CFG0: cfg0 <= hwdata;
                `CSC_A_CFG1: cfg1 <= hwdata;
                `CSC_A_FIXED: fixed_r <= {16'h0, hwdata[15:0]};
                `CSC_A_THD: thd_lim <= {16'h0, hwdata[15:0]};
                `CSC_A_TOD: tod_r <= {8'h0, hwdata[23:0]};
                `CSC_A_DATE: date_r <= {8'h0, hwdata[23:0]};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            log_per <= 2'h0;
            unit_identifier <= `CSC_UNITID_RST;
        end else if (ce && dp_wr && erased) begin
            if (dp_addr == `CSC_A_LOGPER) log_per <= hwdata[1:0];
            if (dp_addr == `CSC_A_UNITID) unit_identifier <= hwdata;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NB; gi++) begin : g_bank
            assign conn[gi] = (5'(gi) < cfg0[`CSC_F_STEPS]);
            assign auto_m[gi] = conn[gi] & ~fixed_r[gi];
            assign locked[gi] = (lock_cnt[gi] != 9'h0);
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    rating[gi] <= `CSC_RATING_RST;
                    op_cnt[gi] <= 32'h0;
                    lock_cnt[gi] <= 9'h0;
                end else if (ce) begin
                    if (dp_wr && dp_addr[7:6] == `CSC_A_RATING && dp_addr[5:2] == 4'(gi))
                        rating[gi] <= hwdata[7:0];
                    if (next_bank_on[gi] & ~bank_on[gi]) op_cnt[gi] <= op_cnt[gi] + 32'h1;
                    if (bank_on[gi] & ~next_bank_on[gi]) lock_cnt[gi] <= cfg1[`CSC_F_DIS];
                    else if (tick && locked[gi]) lock_cnt[gi] <= lock_cnt[gi] - 9'h1;
                end
            end
        end
    endgenerate

    // largest bank that still fits the need
    always_comb begin
        mag = meas.demand[15] ? 16'(-meas.demand) : meas.demand;
        min_rat = 8'hFF;
        on_ok = 1'b0;
        off_ok = 1'b0;
        fix_ok = 1'b0;
        on_idx = 5'h0;
        off_idx = 5'h0;
        fix_idx = 5'h0;
        for (int i = NB - 1; i >= 0; i--) begin
            if (auto_m[i] && rating[i] < min_rat) min_rat = rating[i];
            if (fixed_r[i] && conn[i] && !bank_on[i] && !locked[i]) begin
                fix_ok = 1'b1;
                fix_idx = 5'(i);
            end
            if (auto_m[i] && !bank_on[i] && !locked[i] && {8'h0, rating[i]} <= mag &&
                (!on_ok || rating[i] > rating[on_idx[3:0]])) begin
                on_ok = 1'b1;
                on_idx = 5'(i);
            end
            if (auto_m[i] && bank_on[i] && {8'h0, rating[i]} <= mag &&
                (!off_ok || rating[i] > rating[off_idx[3:0]])) begin
                off_ok = 1'b1;
                off_idx = 5'(i);
            end
        end
        // band = smallest rating * factor, compared against need * 10
        band = {5'h0, min_rat} * {8'h0, cfg0[`CSC_F_SF]};
        out_band = ({7'h0, band} < ({4'h0, mag} * 20'h0000A));
    end

    assign inhibit = clo | chi | fast_off;
    // harmonic overload, all banks off
    // banks stay off while distortion is high, even after a manual reset
    assign fast_off = vh_lat | ih_lat | (cfg0[`CSC_F_HEN] & |hi) | no_load_current_flag;
    assign slot_free = ~il_cnt & ~inhibit;

    always_comb begin
        next_bank_on = bank_on & conn;
        if (fast_off) begin
            next_bank_on = 16'h0;
        end else if (fix_ok && slot_free) begin
            next_bank_on[fix_idx[3:0]] = 1'b1;
        end else if (seq == csc_pkg::SQ_ACT && !meas.demand[15]) begin
            if (on_ok && slot_free) next_bank_on[on_idx[3:0]] = 1'b1;
        end else if (seq == csc_pkg::SQ_ACT && off_ok) begin
            next_bank_on[off_idx[3:0]] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bank_on <= 16'h0;
            il_cnt <= 1'b0;
        end else if (ce) begin
            bank_on <= next_bank_on;
            if (|(next_bank_on & ~bank_on)) il_cnt <= cfg0[`CSC_F_ILV];
            else if (tick) il_cnt <= 1'b0;
        end
    end

    // a turn-on that is inhibited abandons this correction and restarts the wait
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seq <= csc_pkg::SQ_IDLE;
            cor_cnt <= 8'h0;
            ob_cnt <= 2'h0;
            insufficient_capacity_flag <= 1'b0;
        end else if (ce) begin
            unique case (seq)
                csc_pkg::SQ_IDLE: begin
                    cor_cnt <= 8'h0;
                    if (out_band) seq <= csc_pkg::SQ_WAIT;
                end
                csc_pkg::SQ_WAIT: begin
                    if (!out_band) seq <= csc_pkg::SQ_IDLE;
                    else if (cor_cnt >= cfg1[`CSC_F_CORR]) seq <= csc_pkg::SQ_ACT;
                    else if (tick) cor_cnt <= cor_cnt + 8'h1;
                    // two cycles short with all on
                    if (out_band && cor_cnt >= cfg1[`CSC_F_CORR]) begin
                        if (cfg0[`CSC_F_OBEN] && meas.pf_low && (auto_m & ~bank_on) == 16'h0) begin
                            if (ob_cnt != 2'h2) ob_cnt <= ob_cnt + 2'h1;
                            insufficient_capacity_flag <= (ob_cnt != 2'h0);
                        end else begin
                            ob_cnt <= 2'h0;
                            insufficient_capacity_flag <= 1'b0;
                        end
                    end
                end
                csc_pkg::SQ_ACT: begin
                    if (meas.demand[15] || !on_ok || inhibit || !il_cnt) seq <= csc_pkg::SQ_IDLE;
                end
            endcase
            if (!cfg0[`CSC_F_OBEN]) insufficient_capacity_flag <= 1'b0;
        end
    end

    generate
        for (gi = 0; gi < 6; gi++) begin : g_thd
            wire [7:0] smp = (gi < 3) ? meas.vthd[gi % 3] : meas.ithd[gi % 3];
            wire [7:0] lim = (gi < 3) ? thd_lim[`CSC_F_VLIM] : thd_lim[`CSC_F_ILIM];
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    acc[gi] <= 16'h0;
                    hi[gi] <= 1'b0;
                end else if (ce && tick) begin
                    if (win_cnt == 8'(`CSC_AVG_S - 1)) begin
                        acc[gi] <= 16'h0;
                        hi[gi] <= (acc[gi] + 16'(smp)) > ({8'h0, lim} * 16'(`CSC_AVG_S));
                    end else begin
                        acc[gi] <= acc[gi] + 16'(smp);
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            win_cnt <= 8'h0;
            ar_cnt <= 8'h0;
            vh_hi_q <= 1'b0;
            ih_hi_q <= 1'b0;
            vh_lat <= 1'b0;
            ih_lat <= 1'b0;
        end else if (ce) begin
            if (tick) win_cnt <= (win_cnt == 8'(`CSC_AVG_S - 1)) ? 8'h0 : win_cnt + 8'h1;
            vh_hi_q <= |hi[2:0];
            ih_hi_q <= |hi[5:3];
            // auto clear after 180 s low
            if (|hi || !(vh_lat | ih_lat)) ar_cnt <= 8'h0;
            else if (tick && cfg0[`CSC_F_HARST]) ar_cnt <= ar_cnt + 8'h1;
            if (cmd[`CSC_C_MRST] || ar_cnt == 8'(`CSC_ARST_S)) begin
                vh_lat <= 1'b0;
                ih_lat <= 1'b0;
            end
            // a fresh crossing wins over a clear in the same cycle
            if (cfg0[`CSC_F_HEN] && |hi[2:0] && !vh_hi_q) vh_lat <= 1'b1;
            if (cfg0[`CSC_F_HEN] && |hi[5:3] && !ih_hi_q) ih_lat <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clo <= 1'b0;
            chi <= 1'b0;
            batt_warn <= 1'b0;
            no_load_current_flag <= 1'b0;
            voltage_distortion_fault <= 1'b0;
            current_distortion_fault <= 1'b0;
            supply_loss_group_low <= 1'b0;
            supply_loss_group_high <= 1'b0;
            supply_loss_both_groups <= 1'b0;
            batt_flash <= 1'b0;
        end else if (ce) begin
            if (cmd[`CSC_C_MRST]) begin
                clo <= 1'b0;
                chi <= 1'b0;
            end
            if (cfg0[`CSC_F_CEN] && !pins[0]) clo <= 1'b1;
            if (cfg0[`CSC_F_CEN] && !pins[1]) chi <= 1'b1;
            supply_loss_group_low <= clo & ~chi;
            supply_loss_group_high <= chi & ~clo;
            supply_loss_both_groups <= clo & chi;
            if (cmd[`CSC_C_BATCLR]) batt_warn <= 1'b0;
            if (pins[2]) batt_warn <= 1'b1;
            batt_flash <= batt_warn & blink;
            no_load_current_flag <= (meas.load_permil < 10'(`CSC_ZC_PERMIL));
            voltage_distortion_fault <= vh_lat | (cfg0[`CSC_F_HEN] & |hi[2:0]);
            current_distortion_fault <= ih_lat | (cfg0[`CSC_F_HEN] & |hi[5:3]);
        end
    end

    always_comb begin
        unique case (log_per)
            2'h0: per_min = 6'(`CSC_LOGP0_MIN);
            2'h1: per_min = 6'(`CSC_LOGP1_MIN);
            2'h2: per_min = 6'(`CSC_LOGP2_MIN);
            2'h3: per_min = 6'(`CSC_LOGP3_MIN);
        endcase
    end

    assign evt = {no_load_current_flag, voltage_distortion_fault, current_distortion_fault,
        supply_loss_group_low, supply_loss_group_high, batt_warn, insufficient_capacity_flag};
    // logging needs a running calendar clock
    assign ilog_go = pins[3] && tick && sec_cnt == 6'(`CSC_MIN_S - 1) &&
        min_cnt == per_min - 6'h1 && (!ifull || cfg0[`CSC_F_IWRAP]);
    assign elog_go = pins[3] && |(evt & ~evt_q) && (!efull || cfg0[`CSC_F_EWRAP]);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt <= 6'h0;
            min_cnt <= 6'h0;
            evt_q <= 7'h0;
            iptr <= '0;
            eptr <= '0;
            ifull <= 1'b0;
            efull <= 1'b0;
            erased <= 1'b1;
            interval_log <= '0;
            event_log <= '0;
            calendar_clock <= '0;
        end else if (ce) begin
            if (tick) begin
                sec_cnt <= (sec_cnt == 6'(`CSC_MIN_S - 1)) ? 6'h0 : sec_cnt + 6'h1;
                if (sec_cnt == 6'(`CSC_MIN_S - 1))
                    min_cnt <= (min_cnt >= per_min - 6'h1) ? 6'h0 : min_cnt + 6'h1;
            end
            evt_q <= evt;
            interval_log <= {ilog_go, iptr};
            event_log <= {elog_go, eptr};
            if (ilog_go) begin
                iptr <= iptr + 1'b1;
                if (&iptr) ifull <= 1'b1;
            end
            if (elog_go) begin
                eptr <= eptr + 1'b1;
                if (&eptr) efull <= 1'b1;
            end
            if (ilog_go || elog_go) erased <= 1'b0;
            if (cmd[`CSC_C_ERASE]) begin
                iptr <= '0;
                eptr <= '0;
                ifull <= 1'b0;
                efull <= 1'b0;
                erased <= 1'b1;
            end
            calendar_clock <= {cmd[`CSC_C_RTCINIT], tod_r[23:0], date_r[23:0]};
        end
    end
endmodule : csc_top

/* verif/csc_top_props.sv */
`timescale 1ns/1ps
module csc_top_props (
    input wire logic clk_sys, // clock
    input wire logic rst_n, // reset
    input wire logic hreadyout, // bus ready
    input wire logic hresp, // bus response
    input wire csc_pkg::csc_meas_s meas, // metering
    input wire logic rtc_run_pin, // clock running
    input wire logic [15:0] bank_on, // commands
    input wire logic no_load_current_flag, // low load
    input wire logic supply_loss_group_low, // low group
    input wire logic supply_loss_group_high, // high group
    input wire logic supply_loss_both_groups, // both
    input wire csc_pkg::csc_rtc_s calendar_clock, // load strobe
    input wire csc_pkg::csc_log_s interval_log, // interval strobe
    input wire csc_pkg::csc_log_s event_log // event strobe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stalled");
    a_zc_level: assert property ($stable(meas.load_permil)[*2] |->
        no_load_current_flag == (meas.load_permil < 10'h00F)) else $error("zc flag");
    a_zc_all_off: assert property (no_load_current_flag[*2] |-> bank_on == 16'h0000)
        else $error("bank on at zero current");
    a_loss_code: assert property ($onehot0({supply_loss_group_low,
        supply_loss_group_high, supply_loss_both_groups})) else $error("supply code");
    a_supply_inhibit: assert property (|(bank_on & ~$past(bank_on)) |->
        !(supply_loss_group_low || supply_loss_group_high || supply_loss_both_groups))
        else $error("turn-on during supply fault");
    a_cal_pulse: assert property (calendar_clock.load |=> !calendar_clock.load)
        else $error("calendar load long");
    a_log_stopped: assert property (!rtc_run_pin[*4] |-> !interval_log.wr && !event_log.wr)
        else $error("log while clock stopped");
    a_log_pulse: assert property (interval_log.wr |=> !interval_log.wr)
        else $error("interval strobe long");
endmodule : csc_top_props
bind csc_top csc_top_props u_props (.clk_sys, .rst_n, .hreadyout, .hresp, .meas, .rtc_run_pin,
    .bank_on, .no_load_current_flag, .supply_loss_group_low, .supply_loss_group_high,
    .supply_loss_both_groups, .calendar_clock, .interval_log, .event_log);

/* verif/csc_contactor_model.sv */
`timescale 1ns/1ps
module csc_contactor_model (
    input wire logic lose_lo, // cut supply, banks 1-8
    input wire logic lose_hi, // cut supply, banks 9-16
    output logic supply_low_ok_pin, // sense, banks 1-8
    output logic supply_high_ok_pin // sense, banks 9-16
);
    // sense follows the coil fuse directly, no debounce
    assign supply_low_ok_pin = !lose_lo;
    assign supply_high_ok_pin = !lose_hi;
endmodule : csc_contactor_model

/* verif/capacitor_step_switch_control_tb.sv */
`timescale 1ns/1ps
`include "csc_regs.svh"
module capacitor_step_switch_control_tb;
    localparam int TC = 20;
    logic clk_sys, rst_n, hsel, hwrite, hready, hreadyout, rtc_run, lose_lo, lose_hi, zc;
    logic slo, shi, sboth, plo, phi;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [15:0] bank_on;
    csc_pkg::csc_meas_s meas;
    int checks, bad_count, cyc;
    assign hready = hreadyout;
    csc_contactor_model u_far (.lose_lo(lose_lo), .lose_hi(lose_hi), .supply_low_ok_pin(plo),
        .supply_high_ok_pin(phi));
    csc_top #(.TICK_CYC(TC)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .meas(meas),
        .supply_low_ok_pin(plo), .supply_high_ok_pin(phi), .batt_low_pin(1'b0),
        .rtc_run_pin(rtc_run), .bank_on(bank_on), .no_load_current_flag(zc),
        .voltage_distortion_fault(), .current_distortion_fault(), .supply_loss_group_low(slo),
        .supply_loss_group_high(shi), .supply_loss_both_groups(sboth), .batt_flash(),
        .insufficient_capacity_flag(), .calendar_clock(), .interval_log(), .event_log(),
        .unit_identifier());
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic results;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    task automatic wait_on(input logic v);
        for (int n = 0; n < 500 && bank_on[0] !== v; n++) @(posedge clk_sys);
    endtask : wait_on
    task automatic t_regs;
        rd(32'h0, `CSC_CFG0_RST);
        rd(32'h4, `CSC_CFG1_RST);
        rd(32'h18, `CSC_UNITID_RST);
        rd(32'h30, 32'h0);
        rd(32'h80, 32'h0);
    endtask : t_regs
    task automatic t_supply;
        rtc_run <= 1'b0;
        lose_lo <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk({slo, shi, sboth}, 3'h4);
        lose_hi <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk({slo, shi, sboth}, 3'h1);
        xfer(1'b1, 32'hC, 32'h1);
        repeat (4) @(posedge clk_sys);
        chk({slo, shi, sboth}, 3'h1);
        lose_lo <= 1'b0;
        lose_hi <= 1'b0;
        repeat (4) @(posedge clk_sys);
        xfer(1'b1, 32'hC, 32'h1);
        repeat (4) @(posedge clk_sys);
        chk({slo, shi, sboth}, 3'h0);
        rtc_run <= 1'b1;
    endtask : t_supply
    task automatic t_bank;
        xfer(1'b1, 32'h8, 32'h1);
        wait_on(1'b1);
        chk(bank_on, 16'h1);
        rd(32'h80, 32'h1);
        xfer(1'b1, 32'h80, 32'h5);
        rd(32'h80, 32'h1);
        meas.load_permil <= 10'h00E;
        repeat (3) @(posedge clk_sys);
        chk({zc, bank_on}, 17'h10000);
        meas.load_permil <= 10'h00F;
        repeat (3) @(posedge clk_sys);
        chk(zc, 1'b0);
        // discharge is 10 ticks, so half of it must still hold the bank off
        repeat (TC * 5) @(posedge clk_sys);
        chk(bank_on, 16'h0);
        wait_on(1'b1);
        rd(32'h80, 32'h2);
    endtask : t_bank
    task automatic t_auto;
        // band is 12 * 1.5 = 18, bank 5 rated 18 is the best fit for 20
        xfer(1'b1, 32'h4, 32'h000A_0003);
        xfer(1'b1, 32'h54, 32'h12);
        meas.demand <= 16'h0011;
        repeat (TC * 6) @(posedge clk_sys);
        chk(bank_on, 16'h0001);
        meas.demand <= 16'h0014;
        repeat (TC * 2) @(posedge clk_sys);
        chk(bank_on, 16'h0001);
        repeat (TC * 4) @(posedge clk_sys);
        chk(bank_on[5], 1'b1);
        meas.demand <= 16'h0000;
    endtask : t_auto
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        meas = '0;
        meas.load_permil = 10'h1F4;
        rtc_run = 1'b1;
        lose_lo = 1'b0;
        lose_hi = 1'b0;
        checks = 0;
        bad_count = 0;
        cyc = 0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        xfer(1'b1, 32'hC, 32'h1);
        t_regs();
        t_supply();
        t_bank();
        t_auto();
        results();
    end
endmodule : capacitor_step_switch_control_tb
